// file: rtl/abs_pkg.sv
// constants and carrier types of the adc bus slave and module configuration block
`default_nettype none
package abs_pkg;
  // location map, 16-bit locations on even byte addresses
  localparam logic [9:0] LOC_MCR = 10'h000;
  localparam logic [9:0] LOC_ASSIGN = 10'h006;
  localparam logic [9:0] LOC_RO_LO = 10'h006;
  localparam logic [9:0] LOC_RO_HI = 10'h010;
  localparam logic [9:0] LOC_RAM = 10'h100;
  // plain register port offsets
  localparam logic [3:0] REG_MCR = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  // module_config_reg fields and reset values
  localparam int MCR_STOP = 15;
  localparam int MCR_FRZ = 14;
  localparam int MCR_SUPERVISOR_SPACE_BIT = 7;
  localparam logic MCR_STOP_RST = 1'b0;
  localparam logic MCR_FRZ_RST = 1'b0;
  localparam logic MCR_SUPERVISOR_SPACE_BIT_RST = 1'b1;
  localparam logic [3:0] MCR_IARB_RST = 4'h0;
  // read values of refused reads
  localparam logic [15:0] FILL_SUPER = 16'h0000;
  localparam logic [15:0] FILL_ASSIGN = 16'hFFFF;
  // access_class_code bit that marks supervisor
  localparam int FC_SUPER = 2;
  localparam int WAIT_MAX_DEF = 4;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_WORD = 2'h1,
    SZ_LONG = 2'h2
  } abs_size_type;

  typedef struct packed {
    logic [9:0] addr;
    abs_size_type size;
    logic wr;
    logic [2:0] fc;
    logic [31:0] wdata;
  } abs_acc_type;

  typedef struct packed {
    logic [9:0] addr;
    logic [15:0] wdata;
    logic [1:0] be;
    logic wr;
    logic rd;
  } abs_loc_type;
endpackage
`default_nettype wire

// file: rtl/abs_core.sv
// bus_interface_unit access splitter, module_config_reg, stop and freeze control
//
// Operation
// - Accept byte, word, long at any address
// - Two clocks per cycle, zero to WAIT_MAX waits
// - Split accesses as independent cycles, no holding
// - Even byte uses bits 15..8 only
// - Odd byte uses bits 7..0 only
// - Even word moves full location once
// - Odd word: low byte, then next high
// - Even long: two full locations in order
// - Odd long: low, full, high byte cycles
// - Config fields writable, unused bits read zero
// - Stop gates analog clock, aborts sequence
// - Stop: globals open, port/control-zero read-only
// - Stop: RAM kept but inaccessible
// - Stop: control one/two, status reset, read-only
// - Stop holds prescaler and timer in reset
// - Freeze now if idle, else after conversion, mode change or queue 2 abort
// - Save queue pointer when freezing while active
// - Freeze resets analog clock and timer only
// - Drop triggers in freeze, resume from state
// - Freeze enable clear ignores halt line
// - User read refused: 0000 or FFFF
// - User write to protected space ignored
// - Access class code decides supervisor access
// - Supervisor bit restricts whole assignable space
// - Global registers always supervisor-only
//
// Implementation choices: the strobed register port and the register offsets.
`default_nettype none
module abs_core #(
  parameter int WAIT_MAX = abs_pkg::WAIT_MAX_DEF
) (
  input wire logic i_core_clk, // core clock
  input wire logic i_rst, // sync reset
  input wire logic [3:0] i_reg_addr, // plain port address
  input wire logic [15:0] i_reg_wdata, // plain port write data
  input wire logic i_reg_wr, // plain port write strobe
  input wire logic i_reg_rd, // plain port read strobe
  output logic [15:0] o_reg_rdata, // read data, cycle after strobe
  input wire logic i_acc_valid, // module bus access request
  input wire abs_pkg::abs_acc_type i_acc, // access fields
  output logic o_acc_busy, // access in progress
  output logic o_acc_done, // access finished pulse
  output logic [31:0] o_acc_rdata, // read result, right aligned except even byte in bits 15..8
  output abs_pkg::abs_loc_type o_loc, // internal location cycle
  input wire logic [15:0] i_loc_rdata, // location read data
  input wire logic i_loc_busy, // converter uses the location
  input wire logic i_freeze_line, // debug halt line
  input wire logic i_queue_active, // a queue is executing
  input wire logic i_conv_done, // current conversion ended
  input wire logic i_mode_chg, // active queue mode rewritten
  input wire logic i_q2_abort, // queue 2 aborted
  input wire logic [5:0] i_queue_ptr, // queue pointer location
  input wire logic [1:0] i_ext_trig, // external trigger pins
  input wire logic [1:0] i_trig_ack, // queue logic took trigger
  output logic [1:0] o_trig_pend, // recorded trigger events
  output logic o_analog_clk_en, // analog clock enable
  output logic o_abort_seq, // abort conversion sequence pulse
  output logic o_presc_rst, // conversion_clock prescaler reset
  output logic o_timer_rst, // periodic/interval timer reset
  output logic o_stop_hold, // reset control one/two and status
  output logic o_frozen, // freeze active
  output logic o_resume, // freeze left pulse
  output logic [5:0] o_saved_ptr, // saved command word location
  output logic [3:0] o_iarb // arbitration number field
);
  typedef enum logic [3:0] {
    ENG_IDLE = 4'b0001,
    ENG_SEG = 4'b0010,
    ENG_DATA = 4'b0100,
    ENG_SPARE = 4'b1000
  } abs_eng_type;

  typedef struct packed {
    logic stop;
    logic freeze_enable_bit;
    logic supervisor_space_bit;
    logic [3:0] iarb;
    abs_eng_type eng;
    logic [9:0] addr;
    logic [2:0] rem;
    logic [31:0] wq;
    logic [31:0] acc;
    logic byte_even;
    logic wr;
    logic [2:0] fc;
    logic [2:0] waits;
    logic [1:0] lane;
    logic blocked;
    logic fill1;
    logic is_mcr;
    abs_pkg::abs_loc_type loc;
    logic [15:0] rdata16;
    logic done;
    logic busy;
    logic [31:0] acc_rdata;
    logic frozen;
    logic [5:0] saved_ptr;
    logic resume;
    logic abort;
    logic aclk_en;
    logic tmr_rst;
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    logic [1:0] tlev;
    logic [1:0] pend;
  } abs_st_type;

  abs_st_type st;
  abs_st_type next_st;

  if (WAIT_MAX < 1 || WAIT_MAX > 7) begin : g_chk
    $error("WAIT_MAX must be 1 to 7");
  end

  logic [15:0] mcr16;
  logic [15:0] stat16;
  logic [9:0] seg_loc;
  logic [1:0] seg_lane;
  logic seg_super;
  logic seg_quiet;
  logic go;
  logic [15:0] d16;
  logic [15:0] mw;
  logic [2:0] step;
  logic frz_on;

  assign mcr16 = {st.stop, st.freeze_enable_bit, 6'h00, st.supervisor_space_bit, 3'h0, st.iarb};
  assign stat16 = {st.stop, st.frozen, st.busy, 7'h00, st.saved_ptr};
  assign frz_on = st.freeze_enable_bit && i_freeze_line;

  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    next_st.resume = 1'b0;
    next_st.rdata16 = 16'h0000;
    seg_loc = {st.addr[9:1], 1'b0};
    seg_lane = 2'b11;
    seg_super = 1'b0;
    seg_quiet = 1'b0;
    go = 1'b0;
    d16 = 16'h0000;
    mw = 16'h0000;
    step = 3'h2;
    // plain port: module_config_reg and status
    if (i_reg_rd) begin
      if (i_reg_addr == abs_pkg::REG_MCR) begin
        next_st.rdata16 = mcr16;
      end else if (i_reg_addr == abs_pkg::REG_STAT) begin
        next_st.rdata16 = stat16;
      end
    end
    if (i_reg_wr && i_reg_addr == abs_pkg::REG_MCR) begin
      next_st.stop = i_reg_wdata[abs_pkg::MCR_STOP];
      next_st.freeze_enable_bit = i_reg_wdata[abs_pkg::MCR_FRZ];
      next_st.supervisor_space_bit = i_reg_wdata[abs_pkg::MCR_SUPERVISOR_SPACE_BIT];
      next_st.iarb = i_reg_wdata[3:0];
    end
    case (st.eng)
      ENG_IDLE: begin
        if (i_acc_valid) begin
          next_st.addr = i_acc.addr;
          next_st.wr = i_acc.wr;
          next_st.fc = i_acc.fc;
          next_st.acc = 32'h0000_0000;
          next_st.byte_even = (i_acc.size == abs_pkg::SZ_BYTE) && !i_acc.addr[0];
          if (i_acc.size == abs_pkg::SZ_BYTE) begin
            next_st.rem = 3'h1;
            next_st.wq = {i_acc.wdata[7:0], 24'h000000};
          end else if (i_acc.size == abs_pkg::SZ_WORD) begin
            next_st.rem = 3'h2;
            next_st.wq = {i_acc.wdata[15:0], 16'h0000};
          end else begin
            next_st.rem = 3'h4;
            next_st.wq = i_acc.wdata;
          end
          next_st.eng = ENG_SEG;
        end
      end
      ENG_SEG: begin
        // lane choice yields the odd/even byte, word and long patterns
        if (st.addr[0]) begin
          seg_lane = 2'b01;
        end else if (st.rem >= 3'h2) begin
          seg_lane = 2'b11;
        end else begin
          seg_lane = 2'b10;
        end
        seg_super = seg_loc < abs_pkg::LOC_ASSIGN;
        next_st.blocked = !st.fc[abs_pkg::FC_SUPER] && (seg_super || st.supervisor_space_bit);
        next_st.fill1 = !seg_super;
        next_st.is_mcr = seg_loc == abs_pkg::LOC_MCR;
        seg_quiet = next_st.blocked || next_st.is_mcr;
        if (st.stop && seg_loc >= abs_pkg::LOC_RAM) begin
          seg_quiet = 1'b1;
        end
        if (st.stop && st.wr && seg_loc >= abs_pkg::LOC_RO_LO &&
            seg_loc <= abs_pkg::LOC_RO_HI) begin
          seg_quiet = 1'b1;
        end
        next_st.lane = seg_lane;
        next_st.loc.addr = seg_loc;
        next_st.loc.be = seg_lane;
        if (seg_lane == 2'b11) begin
          next_st.loc.wdata = st.wq[31:16];
        end else if (seg_lane == 2'b01) begin
          next_st.loc.wdata = {8'h00, st.wq[31:24]};
        end else begin
          next_st.loc.wdata = {st.wq[31:24], 8'h00};
        end
        next_st.loc.rd = !seg_quiet && !st.wr;
        next_st.loc.wr = !seg_quiet && st.wr;
        next_st.waits = 3'h0;
        next_st.eng = ENG_DATA;
      end
      ENG_DATA: begin
        // contention stretches the cycle, capped so the bus never hangs
        go = !(st.loc.rd || st.loc.wr) || !i_loc_busy ||
             (st.waits == 3'(WAIT_MAX));
        if (!go) begin
          next_st.waits = st.waits + 3'h1;
        end else begin
          if (st.blocked) begin
            d16 = st.fill1 ? abs_pkg::FILL_ASSIGN : abs_pkg::FILL_SUPER;
          end else if (st.is_mcr) begin
            d16 = mcr16;
          end else if (st.loc.rd) begin
            d16 = i_loc_rdata;
          end
          if (st.is_mcr && st.wr && !st.blocked) begin
            mw = {st.lane[1] ? st.loc.wdata[15:8] : mcr16[15:8],
                  st.lane[0] ? st.loc.wdata[7:0] : mcr16[7:0]};
            next_st.stop = mw[abs_pkg::MCR_STOP];
            next_st.freeze_enable_bit = mw[abs_pkg::MCR_FRZ];
            next_st.supervisor_space_bit = mw[abs_pkg::MCR_SUPERVISOR_SPACE_BIT];
            next_st.iarb = mw[3:0];
          end
          // each piece is taken as it comes; no second-word latch
          if (st.lane == 2'b11) begin
            next_st.acc = {st.acc[15:0], d16};
            next_st.wq = {st.wq[15:0], 16'h0000};
            step = 3'h2;
          end else begin
            next_st.acc = {st.acc[23:0], st.lane[0] ? d16[7:0] : d16[15:8]};
            next_st.wq = {st.wq[23:0], 8'h00};
            step = 3'h1;
          end
          next_st.addr = st.addr + 10'(step);
          next_st.rem = st.rem - step;
          next_st.loc.rd = 1'b0;
          next_st.loc.wr = 1'b0;
          if (st.rem == step) begin
            next_st.done = 1'b1;
            next_st.acc_rdata = st.byte_even ? {next_st.acc[23:0], 8'h00} : next_st.acc;
            next_st.eng = ENG_IDLE;
          end else begin
            next_st.eng = ENG_SEG;
          end
        end
      end
      default: begin
        next_st.eng = ENG_IDLE;
      end
    endcase
    // freeze entry and exit
    if (!st.frozen && frz_on && (!i_queue_active || i_conv_done || i_mode_chg ||
        i_q2_abort)) begin
      next_st.frozen = 1'b1;
      if (i_queue_active) begin
        next_st.saved_ptr = i_queue_ptr;
      end
    end else if (st.frozen && !frz_on) begin
      next_st.frozen = 1'b0;
      next_st.resume = 1'b1;
    end
    // external triggers: three-stage sync, agreed level, rising edge records
    next_st.s1 = i_ext_trig;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < 2; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.tlev[i] = st.s3[i];
      end
      if (i_trig_ack[i]) begin
        next_st.pend[i] = 1'b0;
      end
      // set beats ack; freeze discards the event
      if (st.s2[i] == st.s3[i] && st.s3[i] && !st.tlev[i] && !st.frozen) begin
        next_st.pend[i] = 1'b1;
      end
    end
    next_st.abort = next_st.stop && !st.stop;
    next_st.aclk_en = !next_st.stop && !next_st.frozen;
    next_st.tmr_rst = next_st.stop || next_st.frozen;
    next_st.busy = next_st.eng != ENG_IDLE;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      st <= '0;
      st.eng <= ENG_IDLE;
      st.stop <= abs_pkg::MCR_STOP_RST;
      st.freeze_enable_bit <= abs_pkg::MCR_FRZ_RST;
      st.supervisor_space_bit <= abs_pkg::MCR_SUPERVISOR_SPACE_BIT_RST;
      st.iarb <= abs_pkg::MCR_IARB_RST;
      st.aclk_en <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign o_reg_rdata = st.rdata16;
  assign o_acc_busy = st.busy;
  assign o_acc_done = st.done;
  assign o_acc_rdata = st.acc_rdata;
  assign o_loc = st.loc;
  assign o_trig_pend = st.pend;
  assign o_analog_clk_en = st.aclk_en;
  assign o_abort_seq = st.abort;
  assign o_presc_rst = st.stop;
  assign o_timer_rst = st.tmr_rst;
  assign o_stop_hold = st.stop;
  assign o_frozen = st.frozen;
  assign o_resume = st.resume;
  assign o_saved_ptr = st.saved_ptr;
  assign o_iarb = st.iarb;

  property p_seg_two;
    @(posedge i_core_clk) disable iff (i_rst)
    (st.eng == ENG_SEG) |=> (st.eng == ENG_DATA) && (st.waits == 3'h0);
  endproperty
  a_seg_two: assert property (p_seg_two) else $error("segment not followed by data");

  property p_wait_cap;
    @(posedge i_core_clk) disable iff (i_rst)
    (st.eng == ENG_DATA && st.waits == 3'(WAIT_MAX)) |=> (st.eng != ENG_DATA);
  endproperty
  a_wait_cap: assert property (p_wait_cap) else $error("wait states exceed limit");

  property p_no_wait;
    @(posedge i_core_clk) disable iff (i_rst)
    (st.eng == ENG_DATA && !i_loc_busy) |=> (st.eng != ENG_DATA);
  endproperty
  a_no_wait: assert property (p_no_wait) else $error("uncontended cycle stretched");

  property p_blk_wr;
    @(posedge i_core_clk) disable iff (i_rst)
    (st.eng == ENG_DATA && st.blocked) |-> !st.loc.wr && !st.loc.rd;
  endproperty
  a_blk_wr: assert property (p_blk_wr) else $error("refused access strobed");

  property p_fill;
    @(posedge i_core_clk) disable iff (i_rst)
    (st.eng == ENG_DATA && st.blocked && st.lane == 2'b11) |=>
      (st.acc[15:0] == ($past(st.fill1) ? abs_pkg::FILL_ASSIGN : abs_pkg::FILL_SUPER));
  endproperty
  a_fill: assert property (p_fill) else $error("refused read value wrong");

  property p_ram_stop;
    @(posedge i_core_clk) disable iff (i_rst)
    (st.eng == ENG_DATA && $past(st.stop) && st.loc.addr >= abs_pkg::LOC_RAM) |->
      !(st.loc.rd || st.loc.wr);
  endproperty
  a_ram_stop: assert property (p_ram_stop) else $error("ram reached in stop");

  property p_stop_abort;
    @(posedge i_core_clk) disable iff (i_rst)
    $rose(st.stop) |-> st.abort && !st.aclk_en && st.tmr_rst ##1 !st.abort;
  endproperty
  a_stop_abort: assert property (p_stop_abort) else $error("stop entry incomplete");

  property p_frz_idle;
    @(posedge i_core_clk) disable iff (i_rst)
    (st.freeze_enable_bit && i_freeze_line && !i_queue_active && !st.frozen) |=> st.frozen && st.tmr_rst;
  endproperty
  a_frz_idle: assert property (p_frz_idle) else $error("idle freeze late");

  property p_frz_off;
    @(posedge i_core_clk) disable iff (i_rst)
    !st.freeze_enable_bit |=> !st.frozen;
  endproperty
  a_frz_off: assert property (p_frz_off) else $error("froze with freeze disabled");

  property p_save_ptr;
    @(posedge i_core_clk) disable iff (i_rst)
    (!st.frozen && next_st.frozen && i_queue_active) |=> (st.saved_ptr == $past(i_queue_ptr));
  endproperty
  a_save_ptr: assert property (p_save_ptr) else $error("queue pointer not saved");

  property p_trig_drop;
    @(posedge i_core_clk) disable iff (i_rst)
    (st.frozen && !st.pend[0]) |=> !st.pend[0];
  endproperty
  a_trig_drop: assert property (p_trig_drop) else $error("trigger kept in freeze");
endmodule
`default_nettype wire

// file: tb/abs_loc_model.sv
// location store behind the access engine, with converter contention
`default_nettype none
module abs_loc_model (
  input wire logic i_core_clk, // core clock
  input wire abs_pkg::abs_loc_type i_loc, // location cycle from the engine
  input wire logic i_contend, // converter is using the locations
  output logic [15:0] o_rdata, // location data while rd is high
  output logic o_busy // contention seen by the engine
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [512];
  logic [15:0] last = 16'h0000;
  initial begin
    foreach (mem[i]) mem[i] = 16'h0000;
  end
  always @(posedge i_core_clk) begin
    if (i_loc.wr && i_loc.be[1]) mem[i_loc.addr[9:1]][15:8] <= i_loc.wdata[15:8];
    if (i_loc.wr && i_loc.be[0]) mem[i_loc.addr[9:1]][7:0] <= i_loc.wdata[7:0];
    if (i_loc.rd) last <= mem[i_loc.addr[9:1]];
  end
  // released bus shows inverted old data so a late sample never matches
  assign o_rdata = i_loc.rd ? mem[i_loc.addr[9:1]] : ~last;
  assign o_busy = i_contend & (i_loc.rd | i_loc.wr);
endmodule
`default_nettype wire

// file: tb/tb_abs_core.sv
// self-checking bench of the adc bus slave and module configuration block
`default_nettype none
module tb_abs_core;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [3:0] ra = 4'h0;
  logic [15:0] rwd = 16'h0000;
  logic rwr = 1'h0;
  logic rrd = 1'h0;
  logic av = 1'h0;
  abs_pkg::abs_acc_type acc = '0;
  abs_pkg::abs_loc_type loc;
  logic ctd = 1'h0;
  logic fl = 1'h0;
  logic qa = 1'h0;
  logic [2:0] evt = 3'h0;
  logic [5:0] qp = 6'h00;
  logic [1:0] et = 2'h0;
  logic [1:0] tack = 2'h0;
  logic [15:0] rrdat, lrdat, v;
  logic [31:0] ardat, d;
  logic abusy, adone, lbusy, cen, abt, prst, trst, shold, freeze_enable_bit, res;
  logic [5:0] sp;
  logic [1:0] tp;
  logic [3:0] iarb;
  logic [15:0] rm [512];
  int fails = 0;
  int checked = 0;
  int seed = 21;
  int nabt = 0;
  int nres = 0;
  int n;
  always #2 clk = ~clk;
  always @(posedge clk) begin
    nabt += abt;
    nres += res;
  end
  abs_core #(.WAIT_MAX(4)) abs_core_i (
    .i_core_clk(clk), .i_rst(rst), .i_reg_addr(ra), .i_reg_wdata(rwd), .i_reg_wr(rwr),
    .i_reg_rd(rrd), .o_reg_rdata(rrdat), .i_acc_valid(av), .i_acc(acc), .o_acc_busy(abusy),
    .o_acc_done(adone), .o_acc_rdata(ardat), .o_loc(loc), .i_loc_rdata(lrdat),
    .i_loc_busy(lbusy), .i_freeze_line(fl), .i_queue_active(qa), .i_conv_done(evt[0]),
    .i_mode_chg(evt[1]), .i_q2_abort(evt[2]), .i_queue_ptr(qp), .i_ext_trig(et),
    .i_trig_ack(tack), .o_trig_pend(tp), .o_analog_clk_en(cen), .o_abort_seq(abt),
    .o_presc_rst(prst), .o_timer_rst(trst), .o_stop_hold(shold), .o_frozen(freeze_enable_bit),
    .o_resume(res), .o_saved_ptr(sp), .o_iarb(iarb));
  abs_loc_model abs_loc_model_i (
    .i_core_clk(clk), .i_loc(loc), .i_contend(ctd), .o_rdata(lrdat), .o_busy(lbusy));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [15:0] x);
    @(posedge clk);
    rwr <= 1'h1;
    ra <= a;
    rwd <= x;
    @(posedge clk);
    rwr <= 1'h0;
  endtask
  task automatic rreg(input logic [3:0] a);
    @(posedge clk);
    rrd <= 1'h1;
    ra <= a;
    @(posedge clk);
    rrd <= 1'h0;
    #1 v = rrdat;
  endtask
  task automatic arun(input logic [9:0] a, input logic [1:0] sz, input logic w,
                      input logic [2:0] fc, input logic [31:0] wd);
    @(posedge clk);
    av <= 1'h1;
    acc <= '{a, abs_pkg::abs_size_type'(sz), w, fc, wd};
    @(posedge clk);
    av <= 1'h0;
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
      if (n == 1) chk(32'(abusy), 32'h1);
    end while (adone !== 1'h1 && n < 40);
    if (adone !== 1'h1) begin
      fails++;
      results();
    end else begin
      d = ardat;
      chk(32'(abusy), 32'h0);
    end
  endtask
  // bytes go most significant first, each to its lane of a 16-bit location
  function automatic logic [31:0] er(input logic [9:0] a, input int nb);
    logic [31:0] r;
    logic [9:0] b;
    r = 32'h0;
    for (int k = 0; k < nb; k++) begin
      b = a + 10'(k);
      r = {r[23:0], b[0] ? rm[b[9:1]][7:0] : rm[b[9:1]][15:8]};
    end
    if (nb == 1 && !a[0]) r = {r[23:0], 8'h00};
    return r;
  endfunction
  task automatic rw(input logic [9:0] a, input int nb, input logic [31:0] wd);
    logic [9:0] b;
    for (int k = 0; k < nb; k++) begin
      b = a + 10'(k);
      if (b[0]) rm[b[9:1]][7:0] = wd[8 * (nb - 1 - k) +: 8];
      else rm[b[9:1]][15:8] = wd[8 * (nb - 1 - k) +: 8];
    end
  endtask
  task automatic op(input logic [9:0] a, input logic [1:0] sz, input logic w,
                    input logic [31:0] wd);
    arun(a, sz, w, 3'h5, wd);
    if (w) rw(a, 1 << sz, wd);
    else chk(d, er(a, 1 << sz));
  endtask
  initial begin
    foreach (rm[i]) rm[i] = 16'h0000;
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    rreg(abs_pkg::REG_MCR);
    chk(32'(v), 32'h0080);
    wreg(abs_pkg::REG_MCR, 16'hFFFF);
    rreg(abs_pkg::REG_MCR);
    chk(32'(v), 32'hC08F);
    wreg(abs_pkg::REG_MCR, 16'h0080);
    arun(10'h001, 2'h0, 1'h1, 3'h5, 32'h0000_00A5);
    chk(32'(iarb), 32'h5);
    arun(10'h001, 2'h0, 1'h0, 3'h5, 32'h0);
    chk(d, 32'h0000_0085);
    op(10'h020, 2'h1, 1'h1, 32'h0000_1234);
    arun(10'h020, 2'h1, 1'h0, 3'h1, 32'h0);
    chk(d, 32'h0000_FFFF);
    arun(10'h020, 2'h1, 1'h1, 3'h1, 32'h0000_BEEF);
    op(10'h020, 2'h1, 1'h0, 32'h0);
    arun(10'h004, 2'h1, 1'h0, 3'h1, 32'h0);
    chk(d, 32'h0);
    wreg(abs_pkg::REG_MCR, 16'h0000);
    arun(10'h020, 2'h1, 1'h0, 3'h1, 32'h0);
    chk(d, 32'h0000_1234);
    arun(10'h004, 2'h1, 1'h0, 3'h1, 32'h0);
    chk(d, 32'h0);
    arun(10'h001, 2'h0, 1'h1, 3'h1, 32'h0000_000A);
    chk(32'(iarb), 32'h0);
    op(10'h030, 2'h1, 1'h0, 32'h0);
    chk(n, 2);
    @(posedge clk);
    ctd <= 1'h1;
    op(10'h030, 2'h1, 1'h0, 32'h0);
    chk(n, 6);
    op(10'h041, 2'h2, 1'h1, 32'hA1B2_C3D4);
    op(10'h041, 2'h2, 1'h0, 32'h0);
    op(10'h04F, 2'h1, 1'h0, 32'h0);
    for (int i = 0; i < 60; i++) begin
      @(posedge clk);
      ctd <= 1'($random(seed));
      op(10'h040 + 10'($random(seed) & 31), 2'($unsigned($random(seed)) % 3),
         1'($random(seed)), $random(seed));
    end
    @(posedge clk);
    ctd <= 1'h0;
    op(10'h008, 2'h1, 1'h1, 32'h0000_5AA5);
    op(10'h100, 2'h1, 1'h1, 32'h0000_1357);
    wreg(abs_pkg::REG_MCR, 16'h8000);
    tick(2);
    chk(32'({cen, prst, trst, shold}), 32'h7);
    arun(10'h008, 2'h1, 1'h1, 3'h5, 32'h0000_FFFF);
    op(10'h008, 2'h1, 1'h0, 32'h0);
    arun(10'h100, 2'h1, 1'h0, 3'h5, 32'h0);
    chk(d, 32'h0);
    rreg(abs_pkg::REG_MCR);
    chk(32'(v), 32'h8000);
    wreg(abs_pkg::REG_MCR, 16'h0000);
    op(10'h100, 2'h1, 1'h0, 32'h0);
    chk(nabt, 2);
    @(posedge clk);
    et <= 2'h1;
    tick(3);
    et <= 2'h0;
    tick(8);
    chk(32'(tp), 32'h1);
    tack <= 2'h1;
    tick(1);
    tack <= 2'h0;
    fl <= 1'h1;
    tick(4);
    chk(32'({freeze_enable_bit, tp}), 32'h0);
    wreg(abs_pkg::REG_MCR, 16'h4000);
    tick(2);
    chk(32'({freeze_enable_bit, cen, prst, trst}), 32'h9);
    op(10'h020, 2'h1, 1'h0, 32'h0);
    et <= 2'h3;
    tick(3);
    et <= 2'h0;
    tick(8);
    chk(32'(tp), 32'h0);
    fl <= 1'h0;
    tick(3);
    qa <= 1'h1;
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      qp <= 6'(k * 9 + 5);
      fl <= 1'h1;
      tick(4);
      chk(32'(freeze_enable_bit), 32'h0);
      evt <= 3'(1 << k);
      @(posedge clk);
      evt <= 3'h0;
      tick(2);
      chk(32'(freeze_enable_bit), 32'h1);
      chk(32'(sp), k * 9 + 5);
      rreg(abs_pkg::REG_STAT);
      chk(32'(v), 32'h4000 + k * 9 + 5);
      fl <= 1'h0;
      tick(3);
    end
    qa <= 1'h0;
    chk(nres, 4);
    results();
  end
endmodule
`default_nettype wire
